// >>> core/igs_issue_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Four oldest bundles form the candidate window
// - Decide issue and tell queues to advance
// - Width limit holds syllables younger than limit
// - Debug restrict: one issue per queue
// - Step-load restrict adds a stop reason
// - Insert issue bubbles for critical hazards
// - Track fp and load-to-address hazards
// - Fp writers fixed latency, bypass from stage six
// - At least six cycles writer to reader
// - Separation one or two: let execute replay
// - Separation three to five: hold at issue
// - Every fp-pipe fp instruction is writer
// - Listed fp and memory classes are readers
// - Two cycles: replay, reissue without stall
// - Three cycles: three stalls, no replay
// - Window spans four oldest unissued bundles
module igs_issue_scheduler (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] start_syllable,
  input wire logic [11:0] slot_valid,
  input wire logic [35:0] slot_queue,
  input wire logic [11:0] slot_base_stop,
  input wire logic [11:0] slot_fp_writer,
  input wire logic [11:0] slot_fp_reader,
  input wire logic [83:0] slot_fp_dst,
  input wire logic [83:0] slot_fp_src_a,
  input wire logic [83:0] slot_fp_src_b,
  input wire logic [11:0] slot_int_load,
  input wire logic [83:0] slot_int_dst,
  input wire logic [11:0] slot_addr_use,
  input wire logic [83:0] slot_addr_src,
  input wire logic [3:0] issue_width_limit,
  input wire logic debug_issue_restrict,
  input wire logic fp_step_load_restrict,
  output logic [11:0] issue_valid,
  output logic [19:0] queue_advance,
  output logic issue_stage_stall,
  output logic [11:0] fp_replay_expect,
  output logic [127:0] fp_commit_vec
);
  localparam int NS = igs_pkg::NUM_SLOTS;
  localparam int NR = igs_pkg::NUM_REGS;
  localparam int RW = igs_pkg::REG_W;
  localparam int QW = igs_pkg::QUEUE_W;

  // Per-register countdowns: fp writer distance and load distance
  logic [3:0] fp_cnt [NR];
  logic [3:0] ld_cnt [NR];
  logic [11:0] fp_wr_hit [NR];
  logic [11:0] ld_wr_hit [NR];

  // Per-slot stop reasons
  logic [11:0] in_win;
  logic [11:0] width_stop;
  logic [11:0] dbg_stop;
  logic [11:0] step_stop;
  logic [11:0] haz_stop;
  logic [11:0] replay_go;
  logic [11:0] stop;
  logic [11:0] blocked;
  logic [11:0] first_stop;
  logic [11:0] issued_wr;
  logic [11:0] issued_ld;
  logic [127:0] next_commit;

  function automatic logic [3:0] count12(input logic [11:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 12; k++) begin
      c = c + {3'h0, v[k]};
    end
    return c;
  endfunction

  // Per-slot decode; inner loop compares against older slots in the window
  genvar i, j, r, q;
  generate
    for (i = 0; i < NS; i++) begin : g_slot
      localparam logic [3:0] IDX = 4'(i);
      logic [RW-1:0] src_a;
      logic [RW-1:0] src_b;
      logic [RW-1:0] asrc;
      logic [3:0] cnt_a;
      logic [3:0] cnt_b;
      logic [11:0] same_q;
      logic [11:0] older_rd;
      logic [11:0] dep_fp;
      logic [11:0] dep_ld;
      logic band_a;
      logic band_b;
      logic rep_a;
      logic rep_b;
      logic fp_band;
      logic ld_band;
      assign src_a = slot_fp_src_a[i*RW +: RW];
      assign src_b = slot_fp_src_b[i*RW +: RW];
      assign asrc = slot_addr_src[i*RW +: RW];
      assign cnt_a = fp_cnt[src_a];
      assign cnt_b = fp_cnt[src_b];
      // Syllables ahead of the start marker issued last cycle
      assign in_win[i] = (IDX >= {2'h0, start_syllable});
      for (j = 0; j < NS; j++) begin : g_older
        if (j < i) begin : g_lt
          logic older;
          assign older = in_win[j] && slot_valid[j];
          assign same_q[j] = older && (slot_queue[j*QW +: QW] == slot_queue[i*QW +: QW]);
          assign older_rd[j] = older && slot_fp_reader[j];
          // Writer ahead in the same group: zero separation
          assign dep_fp[j] = older && slot_fp_writer[j] &&
                             ((slot_fp_dst[j*RW +: RW] == src_a) ||
                              (slot_fp_dst[j*RW +: RW] == src_b));
          assign dep_ld[j] = older && slot_int_load[j] &&
                             (slot_int_dst[j*RW +: RW] == asrc);
        end else begin : g_ge
          assign same_q[j] = 1'b0;
          assign older_rd[j] = 1'b0;
          assign dep_fp[j] = 1'b0;
          assign dep_ld[j] = 1'b0;
        end
      end
      // Separation three to five sits strictly between both thresholds
      assign band_a = (cnt_a > igs_pkg::FP_CNT_BYPASS) &&
                      (cnt_a < igs_pkg::FP_CNT_REPLAY);
      assign band_b = (cnt_b > igs_pkg::FP_CNT_BYPASS) &&
                      (cnt_b < igs_pkg::FP_CNT_REPLAY);
      assign rep_a = cnt_a >= igs_pkg::FP_CNT_REPLAY;
      assign rep_b = cnt_b >= igs_pkg::FP_CNT_REPLAY;
      assign fp_band = slot_fp_reader[i] && (band_a || band_b || (|dep_fp));
      assign ld_band = slot_addr_use[i] &&
                       ((ld_cnt[asrc] != igs_pkg::CNT_ZERO) || (|dep_ld));
      assign width_stop[i] = IDX > issue_width_limit;
      assign dbg_stop[i] = debug_issue_restrict && (|same_q);
      // Step-load control: one fp register reader per cycle
      assign step_stop[i] = fp_step_load_restrict && slot_fp_reader[i] && (|older_rd);
      assign haz_stop[i] = fp_band || ld_band;
      assign replay_go[i] = slot_fp_reader[i] && !fp_band && (rep_a || rep_b);
      // Invalid slot ends the group like any other stop
      assign stop[i] = in_win[i] && (!slot_valid[i] || slot_base_stop[i] || width_stop[i] ||
                       dbg_stop[i] || step_stop[i] || haz_stop[i]);
      if (i == 0) begin : g_first
        assign blocked[i] = stop[i];
        assign first_stop[i] = stop[i];
      end else begin : g_rest
        assign blocked[i] = blocked[i-1] || stop[i];
        assign first_stop[i] = stop[i] && !blocked[i-1];
      end
      // Everything from the start marker up to the first stop issues
      assign issue_valid[i] = in_win[i] && !blocked[i];
      // Every fp-pipe fp instruction counts as a writer
      assign issued_wr[i] = issue_valid[i] && slot_fp_writer[i];
      assign issued_ld[i] = issue_valid[i] && slot_int_load[i];
    end

    // Queue read points advance by their issued count
    for (q = 0; q < igs_pkg::NUM_QUEUES; q++) begin : g_queue
      logic [11:0] mine;
      for (j = 0; j < NS; j++) begin : g_m
        assign mine[j] = issue_valid[j] && (slot_queue[j*QW +: QW] == 3'(q));
      end
      assign queue_advance[q*igs_pkg::ADV_W +: igs_pkg::ADV_W] = count12(mine);
    end

    // Register scoreboards; a new writer restarts the distance
    for (r = 0; r < NR; r++) begin : g_reg
      for (j = 0; j < NS; j++) begin : g_h
        assign fp_wr_hit[r][j] = issued_wr[j] && (slot_fp_dst[j*RW +: RW] == 7'(r));
        assign ld_wr_hit[r][j] = issued_ld[j] && (slot_int_dst[j*RW +: RW] == 7'(r));
      end
      // Commit in the cycle the writer reaches stage eight
      assign next_commit[r] = (fp_cnt[r] == igs_pkg::FP_CNT_LAST) && !(|fp_wr_hit[r]);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          fp_cnt[r] <= igs_pkg::CNT_ZERO;
        end else if (|fp_wr_hit[r]) begin
          fp_cnt[r] <= igs_pkg::FP_CNT_INIT;
        end else if (fp_cnt[r] != igs_pkg::CNT_ZERO) begin
          fp_cnt[r] <= fp_cnt[r] - 4'h1;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ld_cnt[r] <= igs_pkg::CNT_ZERO;
        end else if (|ld_wr_hit[r]) begin
          ld_cnt[r] <= igs_pkg::LD_CNT_INIT;
        end else if (ld_cnt[r] != igs_pkg::CNT_ZERO) begin
          ld_cnt[r] <= ld_cnt[r] - 4'h1;
        end
      end
    end
  endgenerate

  // Stall flag: the group ended on a hazard bubble
  assign issue_stage_stall = |(first_stop & haz_stop);

  // Registered notices to the execute stage and file write port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_replay_expect <= 12'h000;
      fp_commit_vec <= 128'h0;
    end else begin
      fp_replay_expect <= issue_valid & replay_go;
      fp_commit_vec <= next_commit;
    end
  end

  // Watch helpers on register zero for the timing checks
  logic fp_w0;
  logic fp_r0;
  logic ld_w0;
  logic ld_r0;
  logic [11:0] rd0;
  logic [11:0] ar0;
  logic [11:0] fq_iss;
  logic [11:0] frd_iss;
  generate
    for (j = 0; j < NS; j++) begin : g_watch
      assign rd0[j] = issue_valid[j] && slot_fp_reader[j] &&
                      ((slot_fp_src_a[j*RW +: RW] == 7'h00) ||
                       (slot_fp_src_b[j*RW +: RW] == 7'h00));
      assign ar0[j] = issue_valid[j] && slot_addr_use[j] &&
                      (slot_addr_src[j*RW +: RW] == 7'h00);
      assign fq_iss[j] = issue_valid[j] && (slot_queue[j*QW +: QW] == igs_pkg::Q_FP);
      assign frd_iss[j] = issue_valid[j] && slot_fp_reader[j];
    end
  endgenerate
  assign fp_w0 = |fp_wr_hit[0];
  assign ld_w0 = |ld_wr_hit[0];
  assign fp_r0 = |rd0;
  assign ld_r0 = |ar0;

  // Cycles since the last register-zero writer left issue
  // Saturates, so a long quiet spell never wraps back into the commit slot
  localparam logic [3:0] AGE_ONE = 4'h1;
  localparam logic [3:0] AGE_MAX = 4'hF;
  localparam logic [3:0] AGE_COMMIT = 4'(igs_pkg::ISSUE_TO_READ + igs_pkg::FP_COMMIT_STAGE);
  logic [3:0] w0_age;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w0_age <= igs_pkg::CNT_ZERO;
    end else if (fp_w0) begin
      w0_age <= AGE_ONE;
    end else if ((w0_age != igs_pkg::CNT_ZERO) && (w0_age != AGE_MAX)) begin
      w0_age <= w0_age + AGE_ONE;
    end
  end

  sequence s_fp_write_quiet2;
    fp_w0 ##1 !fp_w0 ##1 !fp_w0;
  endsequence

  property p_no_read_in_band;
    @(posedge sys_clk) disable iff (!rst_n)
      s_fp_write_quiet2 |=> (!fp_r0) [*3];
  endproperty
  a_no_read_in_band: assert property (p_no_read_in_band) else $error("fp reader issued 3-5 cycles after writer");

  property p_commit_at_eight;
    @(posedge sys_clk) disable iff (!rst_n)
      (w0_age == AGE_COMMIT) |-> fp_commit_vec[0];
  endproperty
  a_commit_at_eight: assert property (p_commit_at_eight) else $error("fp commit not 10 cycles after issue");

  property p_no_early_commit;
    @(posedge sys_clk) disable iff (!rst_n)
      fp_w0 |=> !fp_commit_vec[0] [*8];
  endproperty
  a_no_early_commit: assert property (p_no_early_commit) else $error("fp commit too early");

  property p_load_gap;
    @(posedge sys_clk) disable iff (!rst_n)
      ld_w0 |=> !ld_r0;
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("address use right after load");

  property p_width;
    @(posedge sys_clk) disable iff (!rst_n)
      (issue_width_limit < 4'hB) |-> ((issue_valid >> (issue_width_limit + 4'h1)) == 12'h000);
  endproperty
  a_width: assert property (p_width) else $error("syllable beyond width limit issued");

  property p_debug_single;
    @(posedge sys_clk) disable iff (!rst_n)
      debug_issue_restrict |-> (count12(fq_iss) <= 4'h1) && (queue_advance[3:0] <= 4'h1) &&
        (queue_advance[7:4] <= 4'h1) && (queue_advance[11:8] <= 4'h1) &&
        (queue_advance[19:16] <= 4'h1);
  endproperty
  a_debug_single: assert property (p_debug_single) else $error("queue issued twice under debug");

  property p_step_single;
    @(posedge sys_clk) disable iff (!rst_n)
      fp_step_load_restrict |-> count12(frd_iss) <= 4'h1;
  endproperty
  a_step_single: assert property (p_step_single) else $error("two fp readers under step-load");

  property p_advance_sum;
    @(posedge sys_clk) disable iff (!rst_n)
      (queue_advance[3:0] + queue_advance[7:4] + queue_advance[11:8] +
       queue_advance[15:12] + queue_advance[19:16]) == count12(issue_valid);
  endproperty
  a_advance_sum: assert property (p_advance_sum) else $error("queue advance mismatch");

  property p_replay_then_go;
    @(posedge sys_clk) disable iff (!rst_n)
      fp_w0 ##1 (!fp_w0 && fp_r0) |=> (!fp_w0 throughout ##3 1'b1) |-> !fp_r0 [*1];
  endproperty
  a_replay_then_go: assert property (p_replay_then_go) else $error("reader not held after replay");
endmodule
`default_nettype wire

// >>> core/igs_pkg.sv
// Shared constants of the issue group hazard scheduler
package igs_pkg;
  // Issue window shape
  localparam int WIN_BUNDLES = 4;
  localparam int SYL_PER_BUNDLE = 3;
  localparam int NUM_SLOTS = WIN_BUNDLES * SYL_PER_BUNDLE;
  localparam int SLOT_IDX_W = 4;
  localparam int START_W = 2;

  // Instruction queue codes
  localparam int NUM_QUEUES = 5;
  localparam int QUEUE_W = 3;
  localparam logic [2:0] Q_MEM = 3'h0;
  localparam logic [2:0] Q_INT = 3'h1;
  localparam logic [2:0] Q_ALU = 3'h2;
  localparam logic [2:0] Q_FP = 3'h3;
  localparam logic [2:0] Q_BR = 3'h4;
  localparam int ADV_W = 4;

  // Register files
  localparam int NUM_REGS = 128;
  localparam int REG_W = 7;

  // Floating-point writer timing, in pipeline stages and cycles
  localparam int FP_WR_LAT = 6;
  localparam int FP_COMMIT_STAGE = 8;
  localparam int ISSUE_TO_READ = 2;
  localparam int REPLAY_SEP_MAX = 2;
  localparam int CNT_W = 4;
  // Counter value one cycle after a writer leaves the issue stage
  localparam logic [3:0] FP_CNT_INIT = 4'(ISSUE_TO_READ + FP_COMMIT_STAGE - 1);
  // At or below this value the result is bypassable to register-read
  localparam logic [3:0] FP_CNT_BYPASS = 4'(ISSUE_TO_READ + FP_COMMIT_STAGE - FP_WR_LAT);
  // At or above this value the reader goes on and takes an execute replay
  localparam logic [3:0] FP_CNT_REPLAY = 4'(ISSUE_TO_READ + FP_COMMIT_STAGE - REPLAY_SEP_MAX);
  localparam logic [3:0] FP_CNT_LAST = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // Load to address distance; plain default
  localparam int LD_ADDR_GAP = 2;
  localparam logic [3:0] LD_CNT_INIT = 4'(LD_ADDR_GAP - 1);
endpackage

// >>> testbench/igs_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
// Execution side: counts issued instructions and replays taken
module igs_exec_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [19:0] queue_advance,
  input wire logic [11:0] fp_replay_expect,
  output logic [15:0] issued_total,
  output logic [15:0] replay_total
);
  // Per-queue counts summed so the bench can cross-check issue_valid
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      issued_total <= 16'h0000;
      replay_total <= 16'h0000;
    end else begin
      issued_total <= issued_total + 16'(queue_advance[3:0]) + 16'(queue_advance[7:4])
        + 16'(queue_advance[11:8]) + 16'(queue_advance[15:12]) + 16'(queue_advance[19:16]);
      replay_total <= replay_total + 16'($countones(fp_replay_expect));
    end
  end
endmodule
`default_nettype wire

// >>> testbench/igs_issue_scheduler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module igs_issue_scheduler_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] st = 2'h0, start_syllable = 2'h0;
  logic [11:0] sv = 12'h000, fw = 12'h000, fr = 12'h000, il = 12'h000, au = 12'h000;
  logic [11:0] bs = 12'h000, slot_valid = 12'h000, slot_fp_writer = 12'h000;
  logic [11:0] slot_fp_reader = 12'h000, slot_int_load = 12'h000, slot_addr_use = 12'h000;
  logic [11:0] slot_base_stop = 12'h000;
  logic [35:0] sq = 36'h0, slot_queue = 36'h0;
  logic [83:0] fd = 84'h0, fa = {12{7'h7F}}, idst = 84'h0, asrc = {12{7'h7F}};
  logic [83:0] slot_fp_dst = 84'h0, slot_fp_src_a = {12{7'h7F}};
  logic [83:0] slot_int_dst = 84'h0, slot_addr_src = {12{7'h7F}};
  logic [83:0] fb = {12{7'h7F}}, slot_fp_src_b = {12{7'h7F}};
  logic [3:0] lim = 4'hB, issue_width_limit = 4'hB;
  logic dbg = 1'b0, stp = 1'b0, debug_issue_restrict = 1'b0, fp_step_load_restrict = 1'b0;
  logic [11:0] issue_valid, fp_replay_expect;
  logic [19:0] queue_advance;
  logic issue_stage_stall;
  logic [127:0] fp_commit_vec;
  logic [15:0] issued_total, replay_total;
  int errors = 0, num_checks = 0, exp_total = 0;

  always #12.5 sys_clk = ~sys_clk;

  igs_issue_scheduler i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .start_syllable(start_syllable), .slot_valid(slot_valid), .slot_queue(slot_queue),
    .slot_base_stop(slot_base_stop), .slot_fp_writer(slot_fp_writer),
    .slot_fp_reader(slot_fp_reader), .slot_fp_dst(slot_fp_dst),
    .slot_fp_src_a(slot_fp_src_a), .slot_fp_src_b(slot_fp_src_b),
    .slot_int_load(slot_int_load), .slot_int_dst(slot_int_dst),
    .slot_addr_use(slot_addr_use), .slot_addr_src(slot_addr_src),
    .issue_width_limit(issue_width_limit), .debug_issue_restrict(debug_issue_restrict),
    .fp_step_load_restrict(fp_step_load_restrict), .issue_valid(issue_valid),
    .queue_advance(queue_advance), .issue_stage_stall(issue_stage_stall),
    .fp_replay_expect(fp_replay_expect), .fp_commit_vec(fp_commit_vec));

  igs_exec_model i_exec (.sys_clk(sys_clk), .rst_n(rst_n), .queue_advance(queue_advance),
    .fp_replay_expect(fp_replay_expect), .issued_total(issued_total),
    .replay_total(replay_total));

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Wide enough for every result kind; narrower values zero-extend
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Issue check also feeds the expected total for the execution model
  task automatic chk_iss(input logic [11:0] exp, input logic stall);
    exp_total += $countones(exp);
    chk(issue_valid, exp, "issue_valid");
    chk(issue_stage_stall, stall, "stall");
  endtask

  // Staged values are launched together, one assignment per signal per edge
  task automatic step();
    @(posedge sys_clk);
    slot_valid <= sv; slot_queue <= sq; slot_fp_writer <= fw; slot_fp_reader <= fr;
    slot_fp_dst <= fd; slot_fp_src_a <= fa; slot_int_load <= il; slot_int_dst <= idst;
    slot_addr_use <= au; slot_addr_src <= asrc; slot_base_stop <= bs; start_syllable <= st;
    issue_width_limit <= lim; debug_issue_restrict <= dbg; fp_step_load_restrict <= stp;
    slot_fp_src_b <= fb;
    @(negedge sys_clk);
  endtask

  task automatic idle();
    sv = '0; sq = '0; fw = '0; fr = '0; fd = '0; fa = {12{7'h7F}}; il = '0; idst = '0;
    au = '0; asrc = {12{7'h7F}}; fb = {12{7'h7F}}; bs = '0; lim = 4'hB; dbg = 1'b0;
    stp = 1'b0; st = 2'h0;
  endtask

  task automatic put(input int i, input logic [2:0] q);
    sv[i] = 1'b1;
    sq[i*3+:3] = q;
  endtask

  task automatic test_width();
    idle(); put(0, igs_pkg::Q_MEM); put(1, igs_pkg::Q_INT); put(2, igs_pkg::Q_ALU);
    put(3, igs_pkg::Q_FP); put(4, igs_pkg::Q_BR); put(5, igs_pkg::Q_MEM);
    lim = 4'h3; st = 2'h1; step();
    chk_iss(12'h00E, 1'b0);
    chk(queue_advance, 20'h01110, "advance");
    lim = 4'hB; st = 2'h0; bs[2] = 1'b1; step();
    chk_iss(12'h003, 1'b0);
    $display("test_width done");
  endtask

  task automatic test_restrict();
    idle(); put(0, igs_pkg::Q_ALU); put(1, igs_pkg::Q_ALU); put(2, igs_pkg::Q_INT);
    dbg = 1'b1; step();
    chk_iss(12'h001, 1'b0);
    dbg = 1'b0; step();
    chk_iss(12'h007, 1'b0);
    idle(); put(0, igs_pkg::Q_FP); put(1, igs_pkg::Q_FP); fr = 12'h003; stp = 1'b1; step();
    chk_iss(12'h001, 1'b0);
    stp = 1'b0; step();
    chk_iss(12'h003, 1'b0);
    $display("test_restrict done");
  endtask

  // Writer to reg r, then reader on a memory pipe after sep cycles
  task automatic fp_pair(input logic [6:0] r, input int sep);
    idle(); put(0, igs_pkg::Q_FP); fw[0] = 1'b1; fd[6:0] = r; step();
    chk_iss(12'h001, 1'b0);
    idle(); repeat (sep - 1) step();
    put(0, igs_pkg::Q_MEM); fr[0] = 1'b1; fa[6:0] = r; step();
  endtask

  task automatic test_fp();
    fp_pair(7'h00, 1);
    chk_iss(12'h001, 1'b0);
    idle(); step();
    chk(fp_replay_expect, 12'h001, "replay sep1");
    // Replayed reader comes back four cycles on and needs one more bubble
    repeat (2) step();
    put(0, igs_pkg::Q_MEM);
    fr[0] = 1'b1;
    fa[6:0] = 7'h00;
    step();
    chk_iss(12'h000, 1'b1);
    step();
    chk_iss(12'h001, 1'b0);
    fp_pair(7'h0A, 2);
    chk_iss(12'h001, 1'b0);
    idle(); step();
    chk(fp_replay_expect, 12'h001, "replay sep2");
    fp_pair(7'h00, 3);
    chk_iss(12'h000, 1'b1);
    repeat (2) step();
    chk_iss(12'h000, 1'b1);
    step();
    chk_iss(12'h001, 1'b0);
    idle(); step();
    chk(fp_replay_expect, 12'h000, "no replay sep3");
    repeat (3) step();
    chk(fp_commit_vec, 128'h1, "commit");
    idle(); put(0, igs_pkg::Q_FP); put(1, igs_pkg::Q_FP); fw[0] = 1'b1; fd[6:0] = 7'h09;
    fr[1] = 1'b1; fb[13:7] = 7'h09; step();
    chk_iss(12'h001, 1'b1);
    $display("test_fp done");
  endtask

  task automatic test_load_addr();
    idle(); put(0, igs_pkg::Q_MEM); il[0] = 1'b1; idst[6:0] = 7'h00; step();
    chk_iss(12'h001, 1'b0);
    idle(); put(0, igs_pkg::Q_MEM); au[0] = 1'b1; asrc[6:0] = 7'h00; step();
    chk_iss(12'h000, 1'b1);
    step();
    chk_iss(12'h001, 1'b0);
    idle(); step();
    step();
    chk(issued_total, 16'(exp_total), "model issued");
    chk(replay_total, 16'h0002, "model replays");
    $display("test_load_addr done");
  endtask

  // Whole run is well under 100 cycles; 2000 leaves ample margin
  initial begin
    #(25.0 * 2000);
    errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_width();
    test_restrict();
    test_fp();
    test_load_addr();
    end_of_test();
  end
endmodule
`default_nettype wire
